// file: core/table_access_defs.svh
`ifndef TABLE_ACCESS_DEFS_SVH
`define TABLE_ACCESS_DEFS_SVH

// register byte addresses
`define OFS_FIXED_CTRL       16'h041c
`define OFS_ENTRY_WORD_1     16'h0420
`define OFS_ENTRY_WORD_2     16'h0424
`define OFS_ENTRY_WORD_3     16'h0428
`define OFS_ENTRY_WORD_4     16'h042c

// control register fields
`define CTRL_INDEX_HI        21
`define CTRL_INDEX_LO        16
`define CTRL_STATIC_IDX_HI   19
`define CTRL_GO_BIT          7
`define CTRL_SPARE_HI        6
`define CTRL_SPARE_LO        2
`define CTRL_TABLE_BIT       1
`define CTRL_ACTION_BIT      0

// sizes
`define DATA_W               32
`define ADDR_W               16
`define INDEX_W              6
`define STATIC_IDX_W         4
`define SPARE_W              5
`define ENTRY_WORDS          4
`define STATIC_DEPTH         16
`define RSVD_DEPTH           64
`define STATIC_ENTRY_W       128

// field values
`define TABLE_STATIC         1'h0
`define TABLE_RSVD_MCAST     1'h1
`define ACTION_WRITE         1'h0
`define ACTION_READ          1'h1
`define WORD_ZERO            32'h0000_0000
`define RSVD_WORD_SLOT       2'h1

`endif

// file: core/table_access_pkg.sv
package table_access_pkg;
`include "table_access_defs.svh"

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_CAPTURE
  } access_fsm_t;

  typedef logic [`DATA_W-1:0] word_t;

  typedef struct packed {
    access_fsm_t              fsm;
    logic                     go_done_flag;
    logic                     table_sel;
    logic                     action;
    logic [`INDEX_W-1:0]      index;
    logic [`SPARE_W-1:0]      spare;
    word_t [`ENTRY_WORDS-1:0] entry;
    word_t                    rdata;
    logic                     rvalid;
  } access_state_t;

  typedef struct packed {
    logic [`STATIC_ENTRY_W-1:0] rdata;
  } store_state_t;

endpackage : table_access_pkg

// file: core/table_store.sv
`timescale 1ns/100ps
module table_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire logic             wr_en,     // write strobe
  input  wire logic             rd_en,     // read strobe
  input  wire logic [AW-1:0]    addr,      // entry index
  input  wire logic [WIDTH-1:0] wdata,     // entry to store
  output logic      [WIDTH-1:0] rdata      // entry read, one cycle after rd_en
);
  import table_access_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en) begin
      rdata_next = mem[addr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule : table_store

// file: core/fixed_table_access.sv
// Overview of operation
// [R01] reserved multicast entry picked by index 21:16
// [R02] static entry picked by index 19:16 only
// [R03] go bit starts access, self-clears when done
// [R04] table bit one multicast, zero static
// [R05] action bit one reads, zero writes
// [R06] static transfers use all four entry words
// [R07] multicast transfers use entry word two only
// [R08] entry words shared with learned lookup table
// [R09] software loads before write, reads after done
`timescale 1ns/100ps
`include "table_access_defs.svh"
module fixed_table_access (
  input  wire logic                                     core_clk,      // system clock
  input  wire logic                                     rst_n,         // async reset
  input  wire logic [`ADDR_W-1:0]                       reg_addr,      // byte address
  input  wire logic                                     reg_wr,        // write strobe
  input  wire logic                                     reg_rd,        // read strobe
  input  wire logic [`DATA_W-1:0]                       reg_wdata,     // write data
  output logic      [`DATA_W-1:0]                       reg_rdata,     // read data
  output logic                                          reg_rvalid,    // read data valid
  input  wire logic                                     learned_load,  // lookup engine load
  input  wire table_access_pkg::word_t [`ENTRY_WORDS-1:0] learned_entry, // lookup result
  output table_access_pkg::word_t [`ENTRY_WORDS-1:0]    entry_words,   // shared entry words
  output logic                                          access_busy    // access in flight
);
  import table_access_pkg::*;

  access_state_t             st_reg;
  access_state_t             st_next;
  logic                      static_wr;
  logic                      static_rd;
  logic                      rsvd_wr;
  logic                      rsvd_rd;
  logic [`STATIC_ENTRY_W-1:0] static_wdata;
  logic [`STATIC_ENTRY_W-1:0] static_rdata;
  logic [`DATA_W-1:0]        rsvd_rdata;
  logic [`DATA_W-1:0]        ctrl_view;
  logic                      issue;

  assign issue = (st_reg.fsm == ST_ISSUE);

  // strobes to the two tables
  always_comb begin
    static_wr = issue && st_reg.table_sel == `TABLE_STATIC
                && st_reg.action == `ACTION_WRITE; // R04 R05
    static_rd = issue && st_reg.table_sel == `TABLE_STATIC
                && st_reg.action == `ACTION_READ; // R04 R05
    rsvd_wr   = issue && st_reg.table_sel == `TABLE_RSVD_MCAST
                && st_reg.action == `ACTION_WRITE; // R04 R05
    rsvd_rd   = issue && st_reg.table_sel == `TABLE_RSVD_MCAST
                && st_reg.action == `ACTION_READ; // R04 R05
  end

  // word 1 in the top slice of a static entry
  assign static_wdata = {st_reg.entry[0], st_reg.entry[1],
                         st_reg.entry[2], st_reg.entry[3]}; // R06

  table_store #(
    .WIDTH (`STATIC_ENTRY_W),
    .DEPTH (`STATIC_DEPTH),
    .AW    (`STATIC_IDX_W)
  ) u_static (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (static_wr),
    .rd_en    (static_rd),
    .addr     (st_reg.index[`STATIC_IDX_W-1:0]), // R02
    .wdata    (static_wdata),
    .rdata    (static_rdata)
  );

  table_store #(
    .WIDTH (`DATA_W),
    .DEPTH (`RSVD_DEPTH),
    .AW    (`INDEX_W)
  ) u_rsvd (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (rsvd_wr),
    .rd_en    (rsvd_rd),
    .addr     (st_reg.index), // R01
    .wdata    (st_reg.entry[`RSVD_WORD_SLOT]), // R07
    .rdata    (rsvd_rdata)
  );

  // control register as seen by software
  always_comb begin
    ctrl_view = `WORD_ZERO;
    ctrl_view[`CTRL_INDEX_HI:`CTRL_INDEX_LO] = st_reg.index;
    ctrl_view[`CTRL_GO_BIT]                  = st_reg.go_done_flag;
    ctrl_view[`CTRL_SPARE_HI:`CTRL_SPARE_LO] = st_reg.spare;
    ctrl_view[`CTRL_TABLE_BIT]               = st_reg.table_sel;
    ctrl_view[`CTRL_ACTION_BIT]              = st_reg.action;
  end

  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;

    // register reads, answered one cycle later
    if (reg_rd) begin
      st_next.rvalid = 1'b1;
      case (reg_addr)
        `OFS_FIXED_CTRL:   st_next.rdata = ctrl_view;
        `OFS_ENTRY_WORD_1: st_next.rdata = st_reg.entry[0];
        `OFS_ENTRY_WORD_2: st_next.rdata = st_reg.entry[1];
        `OFS_ENTRY_WORD_3: st_next.rdata = st_reg.entry[2];
        `OFS_ENTRY_WORD_4: st_next.rdata = st_reg.entry[3];
        default:           st_next.rdata = `WORD_ZERO;
      endcase
    end

    // one shared set of entry words
    if (learned_load) begin
      st_next.entry = learned_entry; // R08
    end

    if (reg_wr) begin
      case (reg_addr)
        `OFS_ENTRY_WORD_1: st_next.entry[0] = reg_wdata; // R09
        `OFS_ENTRY_WORD_2: st_next.entry[1] = reg_wdata;
        `OFS_ENTRY_WORD_3: st_next.entry[2] = reg_wdata;
        `OFS_ENTRY_WORD_4: st_next.entry[3] = reg_wdata;
        default: ;
      endcase
    end

    case (st_reg.fsm)
      ST_IDLE: begin
        // control is frozen while an access runs
        if (reg_wr && reg_addr == `OFS_FIXED_CTRL) begin
          st_next.index     = reg_wdata[`CTRL_INDEX_HI:`CTRL_INDEX_LO]; // R01
          st_next.spare     = reg_wdata[`CTRL_SPARE_HI:`CTRL_SPARE_LO];
          st_next.table_sel = reg_wdata[`CTRL_TABLE_BIT]; // R04
          st_next.action    = reg_wdata[`CTRL_ACTION_BIT]; // R05
          if (reg_wdata[`CTRL_GO_BIT]) begin
            st_next.go_done_flag = 1'b1; // R03
            st_next.fsm          = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        if (st_reg.action == `ACTION_READ) begin
          st_next.fsm = ST_CAPTURE;
        end else begin
          st_next.go_done_flag = 1'b0; // R03
          st_next.fsm          = ST_IDLE;
        end
      end
      ST_CAPTURE: begin
        if (st_reg.table_sel == `TABLE_RSVD_MCAST) begin
          st_next.entry[`RSVD_WORD_SLOT] = rsvd_rdata; // R07
        end else begin
          st_next.entry[0] = static_rdata[127:96]; // R06
          st_next.entry[1] = static_rdata[95:64];
          st_next.entry[2] = static_rdata[63:32];
          st_next.entry[3] = static_rdata[31:0];
        end
        st_next.go_done_flag = 1'b0; // R03
        st_next.fsm          = ST_IDLE;
      end
      default: begin
        st_next.fsm          = ST_IDLE;
        st_next.go_done_flag = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{fsm: ST_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata   = st_reg.rdata;
  assign reg_rvalid  = st_reg.rvalid;
  assign entry_words = st_reg.entry;
  assign access_busy = st_reg.go_done_flag;

endmodule : fixed_table_access

// file: testbench/fixed_table_access_asserts.sv
`timescale 1ns/100ps
`include "table_access_defs.svh"
module fixed_table_access_asserts (
  input wire logic                                    core_clk,      // clock
  input wire logic                                    rst_n,         // reset
  input wire logic [`ADDR_W-1:0]                      reg_addr,      // address
  input wire logic                                    reg_wr,        // write
  input wire logic                                    reg_rd,        // read
  input wire logic [`DATA_W-1:0]                      reg_wdata,     // wdata
  input wire logic [`DATA_W-1:0]                      reg_rdata,     // rdata
  input wire logic                                    reg_rvalid,    // rvalid
  input wire logic                                    learned_load,  // load
  input wire table_access_pkg::word_t [`ENTRY_WORDS-1:0] learned_entry, // entry
  input wire table_access_pkg::word_t [`ENTRY_WORDS-1:0] entry_words,   // words
  input wire logic                                    access_busy    // busy
);
  import table_access_pkg::*;
  logic act_reg;
  logic mc_reg;
  logic cw;
  logic quiet;
  logic wr_two;
  assign cw = reg_wr && reg_addr == `OFS_FIXED_CTRL && !access_busy;
  assign wr_two = reg_wr && reg_addr == `OFS_ENTRY_WORD_2 && !access_busy;
  assign quiet = access_busy && !learned_load && !reg_wr;
  // remembers the kind of the access in flight
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= 1'b0;
      mc_reg  <= 1'b0;
    end else if (cw) begin
      act_reg <= reg_wdata[`CTRL_ACTION_BIT];
      mc_reg  <= reg_wdata[`CTRL_TABLE_BIT];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_go_sets_busy: assert property (cw && reg_wdata[7] |=> access_busy)
    else $error("go write did not start access");
  chk_busy_self_clears: assert property ($rose(access_busy) |-> ##[1:2] !access_busy)
    else $error("go bit did not clear");
  chk_ctrl_go_read: assert property (reg_rd && reg_addr == `OFS_FIXED_CTRL |=>
    reg_rdata[7] == $past(access_busy) && reg_rdata[15:8] == 8'h00
    && reg_rdata[31:22] == 10'h000)
    else $error("control readback wrong");
  chk_rvalid_follows_rd: assert property (reg_rvalid == $past(reg_rd))
    else $error("read valid misplaced");
  chk_word_two_write: assert property (wr_two |=> entry_words[1] == $past(reg_wdata))
    else $error("entry word write lost");
  chk_learned_load: assert property (learned_load && !reg_wr && !access_busy |=>
    entry_words == $past(learned_entry))
    else $error("shared load lost");
  chk_mcast_other_words: assert property (quiet && mc_reg |=>
    entry_words[0] == $past(entry_words[0]) && entry_words[3:2] == $past(entry_words[3:2]))
    else $error("multicast touched other words");
  chk_write_keeps_words: assert property (quiet && !act_reg |=> $stable(entry_words))
    else $error("write access changed words");
  cover property ($rose(access_busy) && act_reg);
  cover property ($rose(access_busy) && mc_reg);
  cover property (learned_load);
  cover property (access_busy && reg_wr && reg_addr == `OFS_FIXED_CTRL);
endmodule : fixed_table_access_asserts
bind fixed_table_access fixed_table_access_asserts i_chk (.core_clk, .rst_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .learned_load, .learned_entry,
  .entry_words, .access_busy);

// file: testbench/fixed_table_access_tb.sv
`timescale 1ns/100ps
`include "table_access_defs.svh"
module fixed_table_access_tb;
  import table_access_pkg::*;
  logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, learned_load = 0;
  logic [15:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic        reg_rvalid, access_busy;
  word_t [3:0] learned_entry = '0, entry_words;
  int          bad_count = 0, total_checks = 0;
  fixed_table_access i_dut (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .learned_load, .learned_entry, .entry_words, .access_busy);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk);
    reg_rd = 0;
    check({31'h0, reg_rvalid}, 32'h1);
    check(reg_rdata, exp);
  endtask : rd
  task automatic go(input logic [5:0] idx, input logic tbl, input logic act);
    int n;
    wr(`OFS_FIXED_CTRL, {10'h0, idx, 8'h00, 1'b1, 5'h00, tbl, act});
    check({31'h0, access_busy}, 32'h1);
    for (n = 0; n < 8 && access_busy !== 1'b0; n++) @(negedge core_clk);
    if (access_busy !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t access never finished", $time);
      conclude();
    end
    rd(`OFS_FIXED_CTRL, {10'h0, idx, 8'h00, 1'b0, 5'h00, tbl, act});
  endtask : go
  task automatic ld(input logic [31:0] b);
    for (int i = 0; i < 4; i++) wr(`OFS_ENTRY_WORD_1 + 16'(4 * i), b + 32'(i));
  endtask : ld
  task automatic cw(input logic [31:0] b);
    for (int i = 0; i < 4; i++) rd(`OFS_ENTRY_WORD_1 + 16'(4 * i), b + 32'(i));
  endtask : cw
  task automatic t_reset;
    rd(`OFS_FIXED_CTRL, 32'h0);
    rd(`OFS_ENTRY_WORD_4, 32'h0);
    rd(16'h0430, 32'h0);
  endtask : t_reset
  task automatic t_static;
    ld(32'ha000_0000);
    go(6'h33, `TABLE_STATIC, `ACTION_WRITE);
    ld(32'hb000_0000);
    go(6'h05, `TABLE_STATIC, `ACTION_WRITE);
    ld(32'h0);
    go(6'h03, `TABLE_STATIC, `ACTION_READ);
    cw(32'ha000_0000);
  endtask : t_static
  task automatic t_mcast;
    wr(`OFS_ENTRY_WORD_2, 32'h1234_5678);
    go(6'h23, `TABLE_RSVD_MCAST, `ACTION_WRITE);
    wr(`OFS_ENTRY_WORD_2, 32'h0000_0009);
    go(6'h03, `TABLE_RSVD_MCAST, `ACTION_WRITE);
    ld(32'hc000_0000);
    go(6'h23, `TABLE_RSVD_MCAST, `ACTION_READ);
    rd(`OFS_ENTRY_WORD_1, 32'hc000_0000);
    rd(`OFS_ENTRY_WORD_2, 32'h1234_5678);
    rd(`OFS_ENTRY_WORD_4, 32'hc000_0003);
    go(6'h03, `TABLE_STATIC, `ACTION_READ);
    cw(32'ha000_0000);
  endtask : t_mcast
  task automatic t_learned;
    learned_entry = {32'h4, 32'h3, 32'h2, 32'h1};
    @(negedge core_clk);
    learned_load = 1;
    @(negedge core_clk);
    learned_load = 0;
    check(entry_words[0], 32'h1);
    rd(`OFS_ENTRY_WORD_4, 32'h4);
  endtask : t_learned
  task automatic t_rules;
    learned_entry = {32'h8, 32'h7, 32'h6, 32'h5};
    @(negedge core_clk);
    learned_load = 1;
    reg_addr = `OFS_ENTRY_WORD_2;
    reg_wdata = 32'h0000_00aa;
    reg_wr = 1;
    @(negedge core_clk);
    learned_load = 0;
    reg_wr = 0;
    check(entry_words[1], 32'h0000_00aa);
    check(entry_words[3], 32'h0000_0008);
    wr(16'h0430, 32'hffff_ffff);
    wr(`OFS_FIXED_CTRL, {10'h3ff, 6'h2a, 8'hff, 1'b0, 5'h15, `TABLE_RSVD_MCAST, `ACTION_WRITE});
    wr(16'h041e, 32'hffff_ffff);
    rd(`OFS_FIXED_CTRL, {10'h0, 6'h2a, 8'h00, 1'b0, 5'h15, `TABLE_RSVD_MCAST, `ACTION_WRITE});
    rd(16'h0430, 32'h0);
    wr(`OFS_FIXED_CTRL, {10'h0, 6'h05, 8'h00, 1'b1, 5'h00, `TABLE_STATIC, `ACTION_READ});
    wr(`OFS_FIXED_CTRL, {10'h0, 6'h3f, 8'h00, 1'b1, 5'h1f, `TABLE_RSVD_MCAST, `ACTION_WRITE});
    check({31'h0, access_busy}, 32'h0);
    rd(`OFS_FIXED_CTRL, {10'h0, 6'h05, 8'h00, 1'b0, 5'h00, `TABLE_STATIC, `ACTION_READ});
    cw(32'hb000_0000);
  endtask : t_rules
  task automatic t_reset_mid;
    wr(`OFS_FIXED_CTRL, {10'h0, 6'h03, 8'h00, 1'b1, 5'h00, `TABLE_STATIC, `ACTION_READ});
    rst_n = 0;
    repeat (2) @(negedge core_clk);
    check({31'h0, access_busy}, 32'h0);
    rst_n = 1;
    rd(`OFS_FIXED_CTRL, 32'h0);
    rd(`OFS_ENTRY_WORD_2, 32'h0);
    go(6'h03, `TABLE_STATIC, `ACTION_READ);
    cw(32'ha000_0000);
  endtask : t_reset_mid
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1;
    t_reset();
    t_static();
    t_mcast();
    t_learned();
    t_rules();
    t_reset_mid();
    conclude();
  end
endmodule : fixed_table_access_tb
